// [src/rms_defs.svh]
// named constants for the radio mode sequencer
// assumes a single 100 MHz clock; included by bare name
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH

`define RMS_CLK_PERIOD_NS   32'd10
`define RMS_TICK_64US_NS    32'd64000
`define RMS_TICK_4MS1_NS    32'd4100000
`define RMS_TICK_262MS_NS   32'd262000000
`define RMS_MULT_WIDTH      8

`define RMS_BASE_OFF        2'h0
`define RMS_BASE_64US       2'h1
`define RMS_BASE_4MS1       2'h2
`define RMS_BASE_262MS      2'h3

`define RMS_RXS_PAYLOAD_PKT 3'h1
`define RMS_RXS_PAYLOAD_LP  3'h2
`define RMS_RXS_CHECK_PKT   3'h3
`define RMS_RXS_SYNC_OFF    3'h4
`define RMS_RXS_PREAMB_OFF  3'h5

`define RMS_TMO_RELAUNCH    2'h0
`define RMS_TMO_TX          2'h1
`define RMS_TMO_LP          2'h2
`define RMS_TMO_OFF         2'h3

`define RMS_PKT_OFF         3'h0
`define RMS_PKT_TX_DRAINED  3'h1
`define RMS_PKT_LP          3'h2
`define RMS_PKT_RX_SYNTH    3'h3
`define RMS_PKT_RX_DIRECT   3'h4

`define RMS_LAUNCH_LP       2'h0
`define RMS_LAUNCH_RX       2'h1
`define RMS_LAUNCH_TX       2'h2
`define RMS_LAUNCH_TX_LEVEL 2'h3

`endif

// [src/rms_pkg.sv]
// types shared by the radio mode sequencer
// state codes are one-hot literals here; rms_defs.svh is not used
package rms_pkg;

    typedef enum logic [8:0] {
        RMS_HALTED      = 9'h001,
        RMS_LAUNCH_WAIT = 9'h002,
        RMS_IDLE        = 9'h004,
        RMS_TX          = 9'h008,
        RMS_RX          = 9'h010,
        RMS_PKT_DONE    = 9'h020,
        RMS_LP_SEL      = 9'h040,
        RMS_RX_TMO      = 9'h080,
        RMS_SYNTH       = 9'h100
    } rms_state_type;

endpackage

// [src/rms_interval_timer.sv]
// one interval timer: fires mult x base period cycles after arm
// assumes arm and halt are single-cycle synchronous strobes
`timescale 1ns/100ps
`include "rms_defs.svh"

module rms_interval_timer #(
    parameter int unsigned MULT_W    = `RMS_MULT_WIDTH,
    parameter int unsigned BASE1_CYC = `RMS_TICK_64US_NS / `RMS_CLK_PERIOD_NS,
    parameter int unsigned BASE2_CYC = `RMS_TICK_4MS1_NS / `RMS_CLK_PERIOD_NS,
    parameter int unsigned BASE3_CYC = `RMS_TICK_262MS_NS / `RMS_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // control
    input  wire logic              arm_i,
    input  wire logic              halt_i,
    input  wire logic [1:0]        base_i,
    input  wire logic [MULT_W-1:0] mult_i,
    // event
    output logic                   fire_o
);
    logic              active_reg, active_next;
    logic              fire_reg,   fire_next;
    logic [31:0]       cyc_reg,    cyc_next;
    logic [31:0]       period_reg, period_next;
    logic [MULT_W-1:0] cnt_reg,    cnt_next;
    logic [MULT_W-1:0] mult_reg,   mult_next;

    always_comb begin
        active_next = active_reg;
        cyc_next    = cyc_reg;
        period_next = period_reg;
        cnt_next    = cnt_reg;
        mult_next   = mult_reg;
        fire_next   = 1'b0;
        if (halt_i) begin
            active_next = 1'b0;
        end else if (arm_i) begin
            // settings latched here, so later edits wait for the next arm
            cyc_next  = 32'h0;
            cnt_next  = '0;
            mult_next = mult_i;
            unique case (base_i)
                `RMS_BASE_64US:  period_next = BASE1_CYC;
                `RMS_BASE_4MS1:  period_next = BASE2_CYC;
                `RMS_BASE_262MS: period_next = BASE3_CYC;
                `RMS_BASE_OFF:   period_next = period_reg;
            endcase
            // resolution 00 or zero coefficient never fires
            active_next = (base_i != `RMS_BASE_OFF) && (mult_i != '0);
        end else if (active_reg) begin
            if (cyc_reg == period_reg - 32'h1) begin
                cyc_next = 32'h0;
                if (cnt_reg == mult_reg - 1'b1) begin
                    fire_next   = 1'b1;
                    active_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end else begin
                cyc_next = cyc_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_reg <= 1'b0;
            fire_reg   <= 1'b0;
            cyc_reg    <= 32'h0;
            period_reg <= 32'h1;
            cnt_reg    <= '0;
            mult_reg   <= '0;
        end else begin
            active_reg <= active_next;
            fire_reg   <= fire_next;
            cyc_reg    <= cyc_next;
            period_reg <= period_next;
            cnt_reg    <= cnt_next;
            mult_reg   <= mult_next;
        end
    end

    assign fire_o = fire_reg;

endmodule

// [src/rms_rx_exit_decode.sv]
// decodes which receive-state exit the current events request
// assumes event inputs are sampled in the same cycle as the state
`timescale 1ns/100ps
`include "rms_defs.svh"

module rms_rx_exit_decode (
    // selector and events
    input  wire logic [2:0] rx_exit_select_i,
    input  wire logic       payload_avail_evt_i,
    input  wire logic       check_pass_evt_i,
    input  wire logic       sync_match_evt_i,
    input  wire logic       preamble_seen_evt_i,
    // check settings
    input  wire logic       check_enable_i,
    input  wire logic       bad_check_autoflush_i,
    input  wire logic       check_bad_i,
    // requested exit
    output logic            to_pkt_o,
    output logic            to_lp_o,
    output logic            to_halt_o,
    output logic            to_tmo_o
);
    always_comb begin
        to_pkt_o  = 1'b0;
        to_lp_o   = 1'b0;
        to_halt_o = 1'b0;
        to_tmo_o  = 1'b0;
        unique case (rx_exit_select_i)
            `RMS_RXS_PAYLOAD_PKT: to_pkt_o  = payload_avail_evt_i;
            `RMS_RXS_PAYLOAD_LP:  to_lp_o   = payload_avail_evt_i;
            `RMS_RXS_CHECK_PKT: begin
                to_pkt_o = check_pass_evt_i;
                // a bad packet kept in the queue still ends reception
                to_tmo_o = payload_avail_evt_i && check_enable_i
                           && !bad_check_autoflush_i && check_bad_i
                           && !check_pass_evt_i;
            end
            `RMS_RXS_SYNC_OFF:    to_halt_o = sync_match_evt_i;
            `RMS_RXS_PREAMB_OFF:  to_halt_o = preamble_seen_evt_i;
            default: ;
        endcase
    end

endmodule

// [src/rms_sequencer.sv]
// radio mode sequencer: state machine plus two chained interval timers
// assumes all event inputs are synchronous to clk_i, one cycle or level
`timescale 1ns/100ps
`include "rms_defs.svh"

module rms_sequencer #(
    parameter int unsigned MULT_W     = `RMS_MULT_WIDTH,
    parameter int unsigned TICK1_CYC  = `RMS_TICK_64US_NS / `RMS_CLK_PERIOD_NS,
    parameter int unsigned TICK2_CYC  = `RMS_TICK_4MS1_NS / `RMS_CLK_PERIOD_NS,
    parameter int unsigned TICK3_CYC  = `RMS_TICK_262MS_NS / `RMS_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // commands
    input  wire logic              seq_launch_cmd_i,
    input  wire logic              seq_stop_i,
    input  wire logic              start_mode_sleep_i,
    // configuration
    input  wire logic [1:0]        launch_exit_select_i,
    input  wire logic              idle_exit_select_i,
    input  wire logic              tx_exit_select_i,
    input  wire logic [2:0]        rx_exit_select_i,
    input  wire logic [1:0]        timeout_exit_select_i,
    input  wire logic [2:0]        pkt_done_exit_select_i,
    input  wire logic              sleep_choice_i,
    input  wire logic              idle_sleep_select_i,
    input  wire logic              check_enable_i,
    input  wire logic              bad_check_autoflush_i,
    input  wire logic              freq_changed_i,
    // timer settings
    input  wire logic [1:0]        first_tick_base_i,
    input  wire logic [MULT_W-1:0] first_tick_mult_i,
    input  wire logic [1:0]        second_tick_base_i,
    input  wire logic [MULT_W-1:0] second_tick_mult_i,
    // radio events
    input  wire logic              payload_avail_evt_i,
    input  wire logic              check_pass_evt_i,
    input  wire logic              check_bad_i,
    input  wire logic              sync_match_evt_i,
    input  wire logic              preamble_seen_evt_i,
    input  wire logic              strength_expiry_i,
    input  wire logic              preamble_expiry_i,
    input  wire logic              sync_expiry_i,
    input  wire logic              queue_drained_evt_i,
    input  wire logic              queue_level_evt_i,
    input  wire logic              tx_done_evt_i,
    // status
    output logic [8:0]             seq_state_o,
    output logic                   seq_running_o,
    output logic                   lowpower_sleep_o,
    output logic                   rx_relaunch_o,
    output logic                   first_tick_evt_o,
    output logic                   second_tick_evt_o
);
    rms_pkg::rms_state_type state_reg, state_next;
    logic relaunch_reg, relaunch_next;
    logic init_sleep_reg, init_sleep_next;
    logic sleep_reg, sleep_next;
    logic first_tick_evt;
    logic second_tick_evt;
    logic rx_expiry_evt;
    logic launch_take;
    logic rx_to_pkt, rx_to_lp, rx_to_halt, rx_to_tmo;

    assign rx_expiry_evt = strength_expiry_i | preamble_expiry_i | sync_expiry_i;
    // launch only counts while halted; a running sequencer ignores it
    assign launch_take = seq_launch_cmd_i && !seq_stop_i
                         && (state_reg == rms_pkg::RMS_HALTED);

    // timer chain, independent of the sequencer state
    rms_interval_timer #(
        .MULT_W    (MULT_W),
        .BASE1_CYC (TICK1_CYC),
        .BASE2_CYC (TICK2_CYC),
        .BASE3_CYC (TICK3_CYC)
    ) u_first_timer (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .arm_i  (launch_take | second_tick_evt),
        .halt_i (seq_stop_i),
        .base_i (first_tick_base_i),
        .mult_i (first_tick_mult_i),
        .fire_o (first_tick_evt)
    );

    rms_interval_timer #(
        .MULT_W    (MULT_W),
        .BASE1_CYC (TICK1_CYC),
        .BASE2_CYC (TICK2_CYC),
        .BASE3_CYC (TICK3_CYC)
    ) u_second_timer (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .arm_i  (first_tick_evt),
        .halt_i (seq_stop_i),
        .base_i (second_tick_base_i),
        .mult_i (second_tick_mult_i),
        .fire_o (second_tick_evt)
    );

    rms_rx_exit_decode u_rx_exit (
        .rx_exit_select_i      (rx_exit_select_i),
        .payload_avail_evt_i   (payload_avail_evt_i),
        .check_pass_evt_i      (check_pass_evt_i),
        .sync_match_evt_i      (sync_match_evt_i),
        .preamble_seen_evt_i   (preamble_seen_evt_i),
        .check_enable_i        (check_enable_i),
        .bad_check_autoflush_i (bad_check_autoflush_i),
        .check_bad_i           (check_bad_i),
        .to_pkt_o              (rx_to_pkt),
        .to_lp_o               (rx_to_lp),
        .to_halt_o             (rx_to_halt),
        .to_tmo_o              (rx_to_tmo)
    );

    always_comb begin
        state_next      = state_reg;
        relaunch_next   = 1'b0;
        init_sleep_next = init_sleep_reg;
        if (seq_stop_i) begin
            state_next = rms_pkg::RMS_HALTED;
        end else begin
            unique case (state_reg)
                rms_pkg::RMS_HALTED: begin
                    if (launch_take) begin
                        // chip mode at launch is where a halt returns to
                        init_sleep_next = start_mode_sleep_i;
                        unique case (launch_exit_select_i)
                            `RMS_LAUNCH_LP:       state_next = rms_pkg::RMS_LP_SEL;
                            `RMS_LAUNCH_RX:       state_next = rms_pkg::RMS_RX;
                            `RMS_LAUNCH_TX:       state_next = rms_pkg::RMS_TX;
                            `RMS_LAUNCH_TX_LEVEL: state_next = rms_pkg::RMS_LAUNCH_WAIT;
                        endcase
                    end
                end
                rms_pkg::RMS_LAUNCH_WAIT: begin
                    if (queue_level_evt_i) state_next = rms_pkg::RMS_TX;
                end
                rms_pkg::RMS_IDLE: begin
                    if (first_tick_evt) begin
                        state_next = idle_exit_select_i ? rms_pkg::RMS_RX
                                                        : rms_pkg::RMS_TX;
                    end
                end
                rms_pkg::RMS_TX: begin
                    if (tx_done_evt_i) begin
                        state_next = tx_exit_select_i ? rms_pkg::RMS_RX
                                                      : rms_pkg::RMS_LP_SEL;
                    end
                end
                rms_pkg::RMS_RX: begin
                    if (second_tick_evt) state_next = rms_pkg::RMS_LP_SEL;
                    else if (rx_expiry_evt) state_next = rms_pkg::RMS_RX_TMO;
                    else if (rx_to_tmo) state_next = rms_pkg::RMS_RX_TMO;
                    else if (rx_to_pkt) state_next = rms_pkg::RMS_PKT_DONE;
                    else if (rx_to_lp) state_next = rms_pkg::RMS_LP_SEL;
                    else if (rx_to_halt) state_next = rms_pkg::RMS_HALTED;
                end
                rms_pkg::RMS_RX_TMO: begin
                    unique case (timeout_exit_select_i)
                        `RMS_TMO_RELAUNCH: begin
                            state_next    = rms_pkg::RMS_RX;
                            relaunch_next = 1'b1;
                        end
                        `RMS_TMO_TX:  state_next = rms_pkg::RMS_TX;
                        `RMS_TMO_LP:  state_next = rms_pkg::RMS_LP_SEL;
                        `RMS_TMO_OFF: state_next = rms_pkg::RMS_HALTED;
                    endcase
                end
                rms_pkg::RMS_PKT_DONE: begin
                    unique case (pkt_done_exit_select_i)
                        `RMS_PKT_OFF: state_next = rms_pkg::RMS_HALTED;
                        `RMS_PKT_TX_DRAINED: begin
                            if (queue_drained_evt_i) state_next = rms_pkg::RMS_TX;
                        end
                        `RMS_PKT_LP: state_next = rms_pkg::RMS_LP_SEL;
                        `RMS_PKT_RX_SYNTH: begin
                            state_next = freq_changed_i ? rms_pkg::RMS_SYNTH
                                                        : rms_pkg::RMS_RX;
                        end
                        `RMS_PKT_RX_DIRECT: state_next = rms_pkg::RMS_RX;
                        default: ;
                    endcase
                end
                rms_pkg::RMS_SYNTH: state_next = rms_pkg::RMS_RX;
                rms_pkg::RMS_LP_SEL: begin
                    state_next = sleep_choice_i ? rms_pkg::RMS_IDLE
                                                : rms_pkg::RMS_HALTED;
                end
            endcase
        end
    end

    // low-power mode: idle follows its own select, halt returns to launch mode
    always_comb begin
        if (state_next == rms_pkg::RMS_IDLE) begin
            sleep_next = idle_sleep_select_i;
        end else begin
            sleep_next = init_sleep_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg      <= rms_pkg::RMS_HALTED;
            relaunch_reg   <= 1'b0;
            init_sleep_reg <= 1'b0;
            sleep_reg      <= 1'b0;
        end else begin
            state_reg      <= state_next;
            relaunch_reg   <= relaunch_next;
            init_sleep_reg <= init_sleep_next;
            sleep_reg      <= sleep_next;
        end
    end

    assign seq_state_o       = state_reg;
    assign seq_running_o     = (state_reg != rms_pkg::RMS_HALTED);
    assign lowpower_sleep_o  = sleep_reg;
    assign rx_relaunch_o     = relaunch_reg;
    assign first_tick_evt_o  = first_tick_evt;
    assign second_tick_evt_o = second_tick_evt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rx_quiet;
        state_reg == rms_pkg::RMS_RX && !seq_stop_i && !second_tick_evt && !rx_expiry_evt;
    endsequence

    sequence s_live(rms_pkg::rms_state_type st);
        state_reg == st && !seq_stop_i;
    endsequence

    a_stop_forces_off: assert property (
        seq_stop_i |=> state_reg == rms_pkg::RMS_HALTED && !seq_running_o)
        else $error("stop did not halt the sequencer");
    a_rx_payload_exit: assert property (
        s_rx_quiet ##0 (payload_avail_evt_i && rx_exit_select_i == `RMS_RXS_PAYLOAD_PKT)
        |=> state_reg == rms_pkg::RMS_PKT_DONE)
        else $error("payload ready did not reach packet done");
    a_rx_bad_check: assert property (
        s_rx_quiet ##0 (rx_exit_select_i == `RMS_RXS_CHECK_PKT && payload_avail_evt_i
        && check_enable_i && !bad_check_autoflush_i && check_bad_i && !check_pass_evt_i)
        |=> state_reg == rms_pkg::RMS_RX_TMO)
        else $error("bad check did not reach receive timeout");
    a_rx_sync_halt: assert property (
        s_rx_quiet ##0 (rx_exit_select_i == `RMS_RXS_SYNC_OFF && sync_match_evt_i)
        |=> state_reg == rms_pkg::RMS_HALTED)
        else $error("sync match did not halt");
    a_rx_second_tick: assert property (
        (state_reg == rms_pkg::RMS_RX && second_tick_evt && !seq_stop_i)
        |=> state_reg == rms_pkg::RMS_LP_SEL)
        else $error("second timer did not leave receive");
    a_tmo_relaunch: assert property (
        s_live(rms_pkg::RMS_RX_TMO) ##0 (timeout_exit_select_i == `RMS_TMO_RELAUNCH)
        |=> state_reg == rms_pkg::RMS_RX && rx_relaunch_o ##1 !rx_relaunch_o)
        else $error("timeout relaunch not a single pulse in receive");
    a_lp_choice_idle: assert property (
        s_live(rms_pkg::RMS_LP_SEL) ##0 sleep_choice_i
        |=> state_reg == rms_pkg::RMS_IDLE && lowpower_sleep_o == $past(idle_sleep_select_i))
        else $error("low-power choice did not enter idle");
    a_idle_exit: assert property (
        s_live(rms_pkg::RMS_IDLE) ##0 first_tick_evt
        |=> state_reg == ($past(idle_exit_select_i) ? rms_pkg::RMS_RX : rms_pkg::RMS_TX))
        else $error("idle exit went to the wrong state");
    a_tx_exit: assert property (
        s_live(rms_pkg::RMS_TX) ##0 tx_done_evt_i
        |=> state_reg == ($past(tx_exit_select_i) ? rms_pkg::RMS_RX : rms_pkg::RMS_LP_SEL))
        else $error("transmit exit went to the wrong state");
    a_synth_path: assert property (
        s_live(rms_pkg::RMS_PKT_DONE) ##0 (pkt_done_exit_select_i == `RMS_PKT_RX_SYNTH
        && freq_changed_i) |=> state_reg == rms_pkg::RMS_SYNTH
        ##1 (seq_stop_i || state_reg == rms_pkg::RMS_RX) || $past(seq_stop_i))
        else $error("synth detour not taken on the way to receive");

endmodule

// [bench/test_radio_mode_sequencer.sv]
// self-checking bench for rms_sequencer, driven straight at its ports
// assumes tick counts shortened to 4/8/16 cycles and a 100 MHz clock
`timescale 1ns/100ps
module test_radio_mode_sequencer;
    typedef struct packed {
        logic [2:0]  r;
        logic [1:0]  t;
        logic [2:0]  p;
        logic [10:0] e1;
        logic [10:0] e2;
        logic [8:0]  s1;
        logic [8:0]  s2;
    } rms_row_type;
    // ev: payload,pass,sync,preamble,strength,pre_exp,sync_exp,drained,level,sent,bad
    localparam rms_row_type ROWS [12] = '{
        '{3'h1, 2'h0, 3'h4, 11'h001, 11'h000, 9'h020, 9'h010},
        '{3'h2, 2'h0, 3'h0, 11'h001, 11'h000, 9'h040, 9'h001},
        '{3'h3, 2'h0, 3'h0, 11'h002, 11'h000, 9'h020, 9'h001},
        '{3'h3, 2'h3, 3'h0, 11'h401, 11'h000, 9'h080, 9'h001},
        '{3'h4, 2'h0, 3'h0, 11'h004, 11'h000, 9'h001, 9'h001},
        '{3'h5, 2'h0, 3'h0, 11'h008, 11'h000, 9'h001, 9'h001},
        '{3'h0, 2'h0, 3'h0, 11'h010, 11'h000, 9'h080, 9'h010},
        '{3'h0, 2'h1, 3'h0, 11'h020, 11'h000, 9'h080, 9'h008},
        '{3'h0, 2'h2, 3'h0, 11'h040, 11'h000, 9'h080, 9'h040},
        '{3'h1, 2'h0, 3'h1, 11'h001, 11'h080, 9'h020, 9'h008},
        '{3'h1, 2'h0, 3'h2, 11'h001, 11'h000, 9'h020, 9'h040},
        '{3'h1, 2'h0, 3'h3, 11'h001, 11'h000, 9'h020, 9'h100}
    };
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        seq_launch_cmd_i = 1'b0;
    logic        seq_stop_i = 1'b0;
    logic [1:0]  launch_exit_select_i = 2'h0;
    logic        idle_exit_select_i = 1'b1;
    logic        tx_exit_select_i = 1'b0;
    logic        sleep_choice_i = 1'b0;
    logic [2:0]  rx_exit_select_i = 3'h0;
    logic [1:0]  timeout_exit_select_i = 2'h0;
    logic [2:0]  pkt_done_exit_select_i = 3'h0;
    logic [1:0]  fb = 2'h0;
    logic [1:0]  sb = 2'h0;
    logic [7:0]  fm = 8'h00;
    logic [7:0]  sm = 8'h00;
    logic [10:0] ev = 11'h000;
    logic [8:0]  st;
    logic        run;
    logic        lps;
    logic        rl;
    logic        ftk;
    logic        stk;
    logic        start_mode_sleep_i = 1'b0;
    logic        idle_sleep_select_i = 1'b1;
    logic        freq_changed_i = 1'b1;
    int          n_fail = 0;
    int          n_checks = 0;

    rms_sequencer #(.TICK1_CYC(4), .TICK2_CYC(8), .TICK3_CYC(16)) rms_sequencer_inst (
        .clk_i, .rst_i, .seq_launch_cmd_i, .seq_stop_i, .start_mode_sleep_i,
        .launch_exit_select_i, .idle_exit_select_i, .tx_exit_select_i, .rx_exit_select_i,
        .timeout_exit_select_i, .pkt_done_exit_select_i, .sleep_choice_i,
        .idle_sleep_select_i, .check_enable_i(1'b1), .bad_check_autoflush_i(1'b0),
        .freq_changed_i, .first_tick_base_i(fb), .first_tick_mult_i(fm),
        .second_tick_base_i(sb), .second_tick_mult_i(sm),
        .payload_avail_evt_i(ev[0]), .check_pass_evt_i(ev[1]), .check_bad_i(ev[10]),
        .sync_match_evt_i(ev[2]), .preamble_seen_evt_i(ev[3]), .strength_expiry_i(ev[4]),
        .preamble_expiry_i(ev[5]), .sync_expiry_i(ev[6]), .queue_drained_evt_i(ev[7]),
        .queue_level_evt_i(ev[8]), .tx_done_evt_i(ev[9]), .seq_state_o(st),
        .seq_running_o(run), .lowpower_sleep_o(lps), .rx_relaunch_o(rl),
        .first_tick_evt_o(ftk), .second_tick_evt_o(stk));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [8:0] g, input logic [8:0] x);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // stop first so the launch is always taken from the halted state
    task automatic launch(input logic [1:0] l);
        @(posedge clk_i) seq_stop_i <= 1'b1;
        @(posedge clk_i) begin
            seq_stop_i <= 1'b0;
            seq_launch_cmd_i <= 1'b1;
            launch_exit_select_i <= l;
        end
        @(posedge clk_i) seq_launch_cmd_i <= 1'b0;
    endtask

    task automatic wait_tick(input bit second, input int exp);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            #1;
        end while (((second ? stk : ftk) !== 1'b1) && n < 200);
        chk(9'(n), 9'(exp));
    endtask

    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk(st, 9'h001);
        chk(9'(run), 9'h000);
        foreach (ROWS[i]) begin
            @(posedge clk_i) begin
                rx_exit_select_i <= ROWS[i].r;
                timeout_exit_select_i <= ROWS[i].t;
                pkt_done_exit_select_i <= ROWS[i].p;
            end
            launch(2'h1);
            #1 chk(st, 9'h010);
            chk(9'(run), 9'h001);
            @(posedge clk_i) ev <= ROWS[i].e1;
            @(posedge clk_i) ev <= ROWS[i].e2;
            #1 chk(st, ROWS[i].s1);
            @(posedge clk_i) ev <= 11'h000;
            #1 chk(st, ROWS[i].s2);
            if (i == 6) chk(9'(rl), 9'h001);
        end
        // stop and payload in the same cycle: stop must win
        launch(2'h1);
        @(posedge clk_i) begin
            ev <= 11'h001;
            seq_stop_i <= 1'b1;
        end
        @(posedge clk_i) begin
            ev <= 11'h000;
            seq_stop_i <= 1'b0;
        end
        #1 chk(st, 9'h001);
        @(posedge clk_i) begin
            fb <= 2'h1;
            fm <= 8'h02;
            sb <= 2'h2;
            sm <= 8'h02;
            sleep_choice_i <= 1'b1;
        end
        launch(2'h0);
        #1 chk(st, 9'h040);
        wait_tick(1'b0, 8);
        @(posedge clk_i);
        #1 chk(st, 9'h010);
        chk(9'(ftk), 9'h000);
        // wait starts on the edge after the arming edge, so a full 2 x 8 edges
        wait_tick(1'b1, 16);
        @(posedge clk_i);
        #1 chk(st, 9'h040);
        chk(9'(stk), 9'h000);
        @(posedge clk_i);
        #1 chk(st, 9'h004);
        chk(9'(lps), 9'h001);
        wait_tick(1'b0, 7);
        @(posedge clk_i) tx_exit_select_i <= 1'b1;
        launch(2'h3);
        #1 chk(st, 9'h002);
        @(posedge clk_i) ev <= 11'h100;
        @(posedge clk_i) ev <= 11'h000;
        #1 chk(st, 9'h008);
        @(posedge clk_i) ev <= 11'h200;
        @(posedge clk_i) ev <= 11'h000;
        #1 chk(st, 9'h010);
        launch(2'h2);
        #1 chk(st, 9'h008);
        @(posedge clk_i) begin
            ev <= 11'h200;
            tx_exit_select_i <= 1'b0;
        end
        @(posedge clk_i) ev <= 11'h000;
        #1 chk(st, 9'h040);
        // halt from low-power choice falls back to the mode held at launch
        @(posedge clk_i) begin
            start_mode_sleep_i <= 1'b1;
            idle_sleep_select_i <= 1'b0;
            sleep_choice_i <= 1'b0;
        end
        launch(2'h0);
        #1 chk(st, 9'h040);
        @(posedge clk_i);
        #1 chk(st, 9'h001);
        chk(9'(lps), 9'h001);
        @(posedge clk_i) sleep_choice_i <= 1'b1;
        launch(2'h0);
        @(posedge clk_i);
        #1 chk(st, 9'h004);
        chk(9'(lps), 9'h000);
        // unchanged frequency skips the synth detour
        @(posedge clk_i) begin
            freq_changed_i <= 1'b0;
            pkt_done_exit_select_i <= 3'h3;
            rx_exit_select_i <= 3'h1;
        end
        launch(2'h1);
        @(posedge clk_i) ev <= 11'h001;
        @(posedge clk_i) ev <= 11'h000;
        #1 chk(st, 9'h020);
        @(posedge clk_i);
        #1 chk(st, 9'h010);
        // reset in mid-run drops the launch mode as well
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        #1 chk(st, 9'h001);
        chk(9'(lps), 9'h000);
        report_and_stop();
    end
endmodule
